// *** bench/rate_converter_config_chk.sv ***
// assertions on the rate converter register ports
`timescale 1ns/100ps
module rate_converter_config_chk (
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] pstrb,
  input wire logic rate_converter_enable, rate_detect_auto, ratio_m_auto, ratio_n_auto,
  input wire logic [1:0] main_rate_source
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire wc = acc && pwrite && pstrb[0] && paddr == rate_converter_pkg::CTRL_ADDR;
  wire wr = acc && pwrite && pstrb[0] && paddr == rate_converter_pkg::RATIO_ADDR;
  property p_en;
    wc |-> ##2 (rate_converter_enable == $past(pwdata[7], 2));
  endproperty
  a_en: assert property (p_en) else $error("enable not from write");
  property p_det;
    wc |-> ##2 (rate_detect_auto == ($past(pwdata[7], 2) && !$past(pwdata[6], 2)));
  endproperty
  a_det: assert property (p_det) else $error("detect wrong");
  property p_rsv; acc && !pwrite && paddr == rate_converter_pkg::CTRL_ADDR |-> prdata[5:0] == 6'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_auto;
    wr && !pwdata[7] |-> ##2 (main_rate_source == rate_converter_pkg::MAIN_AUTO);
  endproperty
  a_auto: assert property (p_auto) else $error("main rate not auto");
  property p_sel;
    wr && pwdata[7] |-> ##2 (main_rate_source == ($past(pwdata[6], 2) ? 2'h2 : 2'h1));
  endproperty
  a_sel: assert property (p_sel) else $error("main rate source wrong");
  property p_m; wr |-> ##2 (ratio_m_auto == ($past(pwdata[5:3], 2) == 3'h0)); endproperty
  a_m: assert property (p_m) else $error("m auto wrong");
  property p_n; wr |-> ##2 (ratio_n_auto == ($past(pwdata[2:0], 2) == 3'h0)); endproperty
  a_n: assert property (p_n) else $error("n auto wrong");
  property p_rst; $rose(presetn) |-> !rate_converter_enable && main_rate_source == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset value");
endmodule // rate_converter_config_chk
bind rate_converter_config rate_converter_config_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb),
  .rate_converter_enable(rate_converter_enable), .rate_detect_auto(rate_detect_auto),
  .ratio_m_auto(ratio_m_auto), .ratio_n_auto(ratio_n_auto),
  .main_rate_source(main_rate_source));

// *** bench/rate_converter_config_test.sv ***
// self-checking bench for the rate converter registers
`timescale 1ns/100ps
module rate_converter_config_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, en, det, ma, na, rc, e;
  logic [1:0] src;
  logic [2:0] m, n;
  int num_errors = 0, compares = 0;
  localparam logic [31:0] C = rate_converter_pkg::CTRL_ADDR, R = rate_converter_pkg::RATIO_ADDR;
  always #50 pclk = ~pclk;
  rate_converter_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rate_converter_enable(en), .rate_detect_auto(det),
    .main_rate_source(src), .ratio_m(m), .ratio_n(n), .ratio_m_auto(ma), .ratio_n_auto(na),
    .ratio_reserved_code(rc));
  task chk(input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no cycle count assumed; only the watchdog ends a hung access
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
    #1;
  endtask
  task t_reset;
    apb(0, C, '0); chk(r, 32'h0);
    apb(0, R, '0); chk(r, 32'h0);
    chk({en, det, src, ma, na}, 6'h03);
    chk({m, n, rc}, 7'h00);
    apb(0, 32'h10, '0); chk(e, 1'h1);
    $display("reset test done");
  endtask
  task t_ctrl;
    apb(1, C, 32'hC0); apb(0, C, '0); chk(r, 32'hC0);
    chk({en, det}, 2'h2);
    apb(1, C, 32'h80); chk({en, det}, 2'h3);
    apb(1, C, '0); chk(en, 1'h0);
    $display("control test done");
  endtask
  task t_ratio;
    for (int c = 0; c < 8; c++) begin
      if (c == 5 || c == 7) continue;
      apb(1, R, 32'hC0 | (c * 9));
      chk({src, m, n, rc}, {2'h2, c[2:0], c[2:0], 1'h0});
      chk(ma & na, c == 0);
    end
    apb(1, R, 32'h40); chk(src, 2'h0);
    apb(1, R, 32'h80); chk(src, 2'h1);
    $display("ratio test done");
  endtask
  task tally_and_finish;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_reset; t_ctrl; t_ratio;
    tally_and_finish;
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
endmodule // rate_converter_config_test

// *** core/rate_converter_config.sv ***
// APB register bank steering the sample-rate converter
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
// Overview of operation
// - converter runs only while the enable bit 7 of the control register is set.
// - automatic rate detection runs while bit 6 is 0 and enable bit 7 is set, suppressed when bit 6 is 1.
// - control bits 5..0 are reserved read-only zeros; software writes only zero.
// - main custom bit 0 infers main rate; 1 takes it from select bit.
// - select bit 0 picks primary serial port rate, 1 picks secondary.
// - m field bits 5..3: 0 auto, 1,2,3,4,6 literal, 5 and 7 reserved.
// - n field bits 2..0: 0 auto, 1,2,3,4,6 literal, 5 and 7 reserved.
// - ratio register at index 0x18, resets to 0x00, all terms inferred.
// - control register at index 0x17, resets to 0x00, converter disabled.
module rate_converter_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rate_converter_enable,
  output logic rate_detect_auto,
  output logic [1:0] main_rate_source,
  output logic [2:0] ratio_m,
  output logic [2:0] ratio_n,
  output logic ratio_m_auto,
  output logic ratio_n_auto,
  output logic ratio_reserved_code
);

  logic enable_q;
  logic detect_disable_q;
  logic [7:0] ratio_q;
  logic hit_ctrl;
  logic hit_ratio;
  logic setup;
  logic rd_setup;
  logic wr_en;
  logic wr_ctrl;
  logic wr_ratio;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_byte;
  logic [2:0] m_code;
  logic [2:0] n_code;
  logic m_rsvd;
  logic n_rsvd;
  logic [1:0] main_d;

  // reserved ratio codes are only flagged; the datapath decides what they mean
  function automatic logic code_reserved(input logic [2:0] code);
    code_reserved = (code == rate_converter_pkg::RATIO_RSVD_A)
      || (code == rate_converter_pkg::RATIO_RSVD_B);
  endfunction

  assign hit_ctrl = (paddr == rate_converter_pkg::CTRL_ADDR);
  assign hit_ratio = (paddr == rate_converter_pkg::RATIO_ADDR);
  // no wait state: answer in the first access cycle after setup, pready registered
  assign setup = psel && !penable;
  assign rd_setup = setup && !pwrite;
  // writes land only on the edge that completes the access phase
  assign wr_en = psel && penable && pready && pwrite && pstrb[0];
  assign wr_ctrl = wr_en && hit_ctrl;
  assign wr_ratio = wr_en && hit_ratio;
  // reserved low bits always read zero
  assign ctrl_rd = {enable_q, detect_disable_q, 6'h00};
  assign m_code = ratio_q[rate_converter_pkg::RATIO_M_LSB +: rate_converter_pkg::RATIO_W];
  assign n_code = ratio_q[rate_converter_pkg::RATIO_N_LSB +: rate_converter_pkg::RATIO_W];
  assign m_rsvd = code_reserved(m_code);
  assign n_rsvd = code_reserved(n_code);

  always_comb begin
    case ({ratio_q[rate_converter_pkg::MAIN_CUSTOM_BIT], ratio_q[rate_converter_pkg::MAIN_SELECT_BIT]})
      2'b10: begin
        main_d = rate_converter_pkg::MAIN_PRIMARY;
      end
      2'b11: begin
        main_d = rate_converter_pkg::MAIN_SECONDARY;
      end
      default: begin
        // select bit ignored while the custom bit is clear
        main_d = rate_converter_pkg::MAIN_AUTO;
      end
    endcase
  end

  always_comb begin
    case ({hit_ctrl, hit_ratio})
      2'b10: begin
        rd_byte = ctrl_rd;
      end
      2'b01: begin
        rd_byte = ratio_q;
      end
      default: begin
        // unmapped words read as zero
        rd_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !hit_ctrl && !hit_ratio;
    end
  end

  // latched at setup so read data stands for the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= rate_converter_pkg::CTRL_RESET[rate_converter_pkg::ENABLE_BIT];
    end else if (wr_ctrl) begin
      // writes to reserved bits 5..0 are dropped
      enable_q <= pwdata[rate_converter_pkg::ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_disable_q <= rate_converter_pkg::CTRL_RESET[rate_converter_pkg::DETECT_DISABLE_BIT];
    end else if (wr_ctrl) begin
      detect_disable_q <= pwdata[rate_converter_pkg::DETECT_DISABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_q <= rate_converter_pkg::RATIO_RESET;
    end else if (wr_ratio) begin
      // reserved ratio codes are stored as written
      ratio_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_converter_enable <= 1'b0;
    end else begin
      rate_converter_enable <= enable_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_detect_auto <= 1'b0;
    end else begin
      // detection only meaningful while the converter itself runs
      rate_detect_auto <= enable_q && !detect_disable_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_rate_source <= rate_converter_pkg::MAIN_AUTO;
    end else begin
      main_rate_source <= main_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_m <= rate_converter_pkg::RATIO_AUTO;
    end else begin
      ratio_m <= m_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_n <= rate_converter_pkg::RATIO_AUTO;
    end else begin
      ratio_n <= n_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_m_auto <= 1'b1;
    end else begin
      ratio_m_auto <= (m_code == rate_converter_pkg::RATIO_AUTO);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_n_auto <= 1'b1;
    end else begin
      ratio_n_auto <= (n_code == rate_converter_pkg::RATIO_AUTO);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_reserved_code <= 1'b0;
    end else begin
      // flag only; the datapath decides what reserved codes do
      ratio_reserved_code <= m_rsvd || n_rsvd;
    end
  end

endmodule // rate_converter_config

// *** core/rate_converter_pkg.sv ***
// constants for the rate converter configuration registers
package rate_converter_pkg;
  // register offsets are not all multiples of four: printed offsets are indices
  localparam logic [7:0] CTRL_INDEX = 8'h17;
  localparam logic [7:0] RATIO_INDEX = 8'h18;
  localparam logic [31:0] CTRL_ADDR = {22'h000000, CTRL_INDEX, 2'b00};
  localparam logic [31:0] RATIO_ADDR = {22'h000000, RATIO_INDEX, 2'b00};
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RATIO_RESET = 8'h00;
  // field positions
  localparam int ENABLE_BIT = 7;
  localparam int DETECT_DISABLE_BIT = 6;
  localparam int MAIN_CUSTOM_BIT = 7;
  localparam int MAIN_SELECT_BIT = 6;
  localparam int RATIO_M_LSB = 3;
  localparam int RATIO_N_LSB = 0;
  localparam int RATIO_W = 3;
  // ratio codes
  localparam logic [2:0] RATIO_AUTO = 3'h0;
  localparam logic [2:0] RATIO_RSVD_A = 3'h5;
  localparam logic [2:0] RATIO_RSVD_B = 3'h7;
  // main rate source encoding on main_rate_source output
  localparam logic [1:0] MAIN_AUTO = 2'h0;
  localparam logic [1:0] MAIN_PRIMARY = 2'h1;
  localparam logic [1:0] MAIN_SECONDARY = 2'h2;
endpackage
